/* File: design/exec_pkg.sv */
// shared constants and types for the four-instruction execute unit
package exec_pkg;
  localparam int unsigned word_w = 14;
  localparam int unsigned data_w = 8;
  localparam int unsigned index_w = 7;
  localparam int unsigned file_depth = 128;
  // opcode patterns in the upper bits
  localparam logic [5:0] op_or_imm = 6'h38;        // 11 1000
  localparam logic [5:0] op_or_reg = 6'h04;        // 00 0100
  localparam logic [5:0] op_move_reg = 6'h08;      // 00 1000
  localparam logic [3:0] op_load_imm_hi = 4'hc;    // 11 00xx, top four bits
  // field positions
  localparam int unsigned opcode_lsb = 8;
  localparam int unsigned dest_bit = 7;
  localparam int unsigned load_hi_lsb = 10;
  // reset values
  localparam logic [7:0] accum_reset = 8'h00;
  localparam logic [7:0] file_reset = 8'h00;
  localparam logic zero_reset = 1'b0;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } instr_s;

  typedef struct packed {
    logic [7:0] accum;
    logic zero;
    logic done;
  } core_state_s;

  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_ori = 3'b001,
    op_orr = 3'b010,
    op_mov = 3'b011,
    op_ldi = 3'b100
  } op_e;
endpackage

/* File: design/instr_decode.sv */
// opcode decoder and operand field extraction
`timescale 1ns/1ps
module instr_decode
  import exec_pkg::*;
(
  input wire exec_pkg::instr_s instr,
  output exec_pkg::op_e op,
  output logic [7:0] imm,
  output logic [6:0] index,
  output logic to_file
);
  // pattern matching on the upper bits
  wire [5:0] top6 = instr.word[13:opcode_lsb];
  wire [3:0] top4 = instr.word[13:load_hi_lsb];
  wire is_ori = instr.valid && (top6 == op_or_imm);
  wire is_orr = instr.valid && (top6 == op_or_reg);
  wire is_mov = instr.valid && (top6 == op_move_reg);
  wire is_ldi = instr.valid && (top4 == op_load_imm_hi);

  assign op = is_ori ? op_ori :
              is_orr ? op_orr :
              is_mov ? op_mov :
              is_ldi ? op_ldi : op_none;
  // operand fields
  assign imm = instr.word[7:0];
  assign index = instr.word[6:0];
  assign to_file = instr.word[dest_bit];
endmodule

/* File: design/or_and_move_instruction_exec.sv */
// single-cycle execute unit for or, move and load-immediate instructions
// Functional notes
// - or immediate byte into accumulator
// - or accumulator with indexed file register
// - dest bit 0 accumulator, 1 file
// - move register reads indexed file register
// - move dest 0 accumulator, 1 same register
// - move always updates zero flag
// - load immediate into accumulator, flags kept
// - load opcode low two bits ignored
// - immediates are low byte, 0..255
`timescale 1ns/1ps
module or_and_move_instruction_exec
  import exec_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire exec_pkg::instr_s instr,
  output exec_pkg::core_state_s state,
  output logic [7:0] file_rd_data
);
  import exec_pkg::*;

  // decoded operation and operand fields
  op_e op;
  logic [7:0] imm;
  logic [6:0] index;
  logic to_file;

  // opcode decoder and field extraction
  instr_decode u_dec (
    .instr(instr),
    .op(op),
    .imm(imm),
    .index(index),
    .to_file(to_file)
  );

  // bitwise or of two bytes
  function automatic logic [7:0] or_bytes(input logic [7:0] a, input logic [7:0] b);
  begin
    or_bytes = a | b;
  end
  endfunction

  // true when a byte is all zeros
  function automatic logic byte_is_zero(input logic [7:0] v);
  begin
    byte_is_zero = (v == 8'h00);
  end
  endfunction

  // true for the two instructions that name a file register
  function automatic logic names_file(input op_e o);
  begin
    names_file = (o == op_orr) || (o == op_mov);
  end
  endfunction

  // true for the instructions that write the zero flag
  function automatic logic writes_zero(input op_e o);
  begin
    writes_zero = (o == op_ori) || (o == op_orr) || (o == op_mov);
  end
  endfunction

  // true for the two immediate forms, which always write the accumulator
  function automatic logic imm_to_accum(input op_e o);
  begin
    imm_to_accum = (o == op_ori) || (o == op_ldi);
  end
  endfunction

  // state registers and their next values
  logic [7:0] accum_r;
  logic [7:0] accum_nxt;
  logic zero_r;
  logic zero_nxt;
  logic done_r;
  logic done_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic [7:0] file_r [file_depth];

  // one wire per decoded operation
  wire is_ori = (op == op_ori);
  wire is_orr = (op == op_orr);
  wire is_mov = (op == op_mov);
  wire is_ldi = (op == op_ldi);
  wire is_any = (op != op_none);

  // operand read; a 7-bit index always lands in the 128 registers
  wire [6:0] file_addr = index;
  wire [7:0] file_val = file_r[file_addr];

  // immediate byte, taken from the low byte of the word
  wire [7:0] load_val = imm;

  // results of the two or forms
  wire [7:0] or_imm_res = or_bytes(accum_r, load_val);
  wire [7:0] or_reg_res = or_bytes(accum_r, file_val);

  // result of a file register instruction, before routing
  wire reg_op = names_file(op);
  wire [7:0] reg_res = is_orr ? or_reg_res : file_val;

  // destination routing by the target choice bit
  wire file_we = reg_op && to_file;
  wire acc_from_reg = reg_op && !to_file;
  wire acc_we = imm_to_accum(op) || acc_from_reg;
  wire [7:0] file_wdata = reg_res;

  // zero flag source; load leaves every flag alone
  wire flag_we = writes_zero(op);
  wire [7:0] result = is_ori ? or_imm_res : reg_res;
  wire result_zero = byte_is_zero(result);

  // next accumulator: load takes the immediate, others their result
  always_comb
  begin
    accum_nxt = accum_r;
    if (is_ldi)
      accum_nxt = load_val;
    else if (acc_we)
      accum_nxt = result;
  end

  // next zero flag, held unless an or or a move runs
  always_comb
  begin
    zero_nxt = zero_r;
    if (flag_we)
      zero_nxt = result_zero;
  end

  // next done pulse and result bus
  always_comb
  begin
    done_nxt = is_any;
    rd_nxt = is_ldi ? load_val : result;
  end

  // accumulator, updated every cycle with no stall
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      accum_r <= accum_reset;
    end
    else
    begin
      accum_r <= accum_nxt;
    end
  end

  // zero flag
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      zero_r <= zero_reset;
    end
    else
    begin
      zero_r <= zero_nxt;
    end
  end

  // one-cycle pulse per recognised instruction
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= done_nxt;
    end
  end

  // result bus of the last cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_r <= file_reset;
    end
    else
    begin
      rd_r <= rd_nxt;
    end
  end

  // file register storage, one writer per register
  genvar gi;
  generate
    for (gi = 0; gi < file_depth; gi++)
    begin : g_file
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          file_r[gi] <= file_reset;
        end
        else if (file_we && (file_addr == 7'(gi)))
        begin
          file_r[gi] <= file_wdata;
        end
      end
    end
  endgenerate

  // outputs straight from the registers
  assign state.accum = accum_r;
  assign state.zero = zero_r;
  assign state.done = done_r;
  assign file_rd_data = rd_r;
endmodule

/* File: test/exec_props.sv */
// execute unit port checks
`timescale 1ns/1ps
module exec_props
  import exec_pkg::*;
(
  input logic clk,
  input logic reset,
  input instr_s instr,
  input core_state_s state
);
  // decoded request kinds
  wire [7:0] a = state.accum, k = instr.word[7:0];
  wire [5:0] op = instr.word[13:8];
  wire v = instr.valid, z = state.zero;
  wire ori = v && op == op_or_imm, ldi = v && op[5:2] == op_load_imm_hi;
  wire mv = v && op == op_move_reg, fr = mv || (v && op == op_or_reg);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_or_val: assert property (ori |=> a == ($past(a) | $past(k))) else $error("or");
  a_or_zero: assert property (ori |=> z == ~|a) else $error("or zero");
  a_ld_val: assert property (ldi |=> a == $past(k)) else $error("load");
  a_ld_flag: assert property (ldi |=> $stable(z)) else $error("load flag");
  a_to_file: assert property (fr && k[7] |=> $stable(a)) else $error("to file");
  a_mv_zero: assert property (mv && !k[7] |=> z == ~|a) else $error("move zero");
  a_one_cyc: assert property (ori || ldi || fr |=> state.done) else $error("done");
  a_idle: assert property (!v |=> !state.done && $stable(a)) else $error("idle");
endmodule
bind or_and_move_instruction_exec exec_props i_props (.clk(clk), .reset(reset),
  .instr(instr), .state(state));

/* File: test/prog_mem.sv */
// program memory model
`timescale 1ns/1ps
module prog_mem (
  input logic fetch,
  input logic [13:0] word,
  output exec_pkg::instr_s instr
);
  // idle bus shows the inverted word
  assign instr = {fetch, fetch ? word : ~word};
endmodule

/* File: test/tb_or_and_move_instruction_exec.sv */
// execute unit bench
`timescale 1ns/1ps
module tb_or_and_move_instruction_exec;
  import exec_pkg::*;
  logic clk = 0, reset = 1, fetch = 0;
  logic [13:0] word = 14'h0000;
  instr_s instr;
  core_state_s state;
  logic [7:0] rd;
  int n_errors = 0, n_tests = 0, cyc = 0;
  prog_mem i_mem (.fetch(fetch), .word(word), .instr(instr));
  or_and_move_instruction_exec i_dut (.clk(clk), .reset(reset), .instr(instr),
    .state(state), .file_rd_data(rd));
  initial forever #20 clk = ~clk;
  // two words back to back, then check zero and accumulator
  task go(input logic [13:0] x, y, input logic [8:0] e);
    @(negedge clk) {fetch, word} = {1'b1, x};
    @(negedge clk) word = y;
    @(negedge clk) fetch = 0;
    n_tests++;
    if ({state.zero, state.accum} !== e)
    begin
      n_errors++;
      $display("Error state exp %h got %h", e, {state.zero, state.accum});
    end
  endtask
  // all four values of the ignored load bits
  task t_load();
    for (int i = 0; i < 4; i++)
      go({4'hc, i[1:0], 8'h00}, {4'hc, i[1:0], 8'hff}, 9'h0ff);
  endtask
  // or and move forms, file written then read back, zero set and kept
  task t_ops();
    go(14'h309a, 14'h3835, 9'h0bf);
    go(14'h3013, 14'h0485, 9'h013);
    go(14'h3091, 14'h0405, 9'h093);
    n_tests++;
    if (rd !== 8'h93)
    begin
      n_errors++;
      $display("Error file_rd_data exp %h got %h", 8'h93, rd);
    end
    go(14'h0805, 14'h0889, 9'h113);
    go(14'h3000, 14'h3800, 9'h100);
    go(14'h3800, 14'h3155, 9'h155);
  endtask
  task print_verdict(input int t);
    n_errors += t;
    if (n_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // cycle ceiling
  always @(posedge clk)
    if (++cyc == 300)
      print_verdict(1);
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk) reset = 0;
    t_load();
    t_ops();
    print_verdict(0);
  end
endmodule
